// ---- bench/pdb_battery_requests_tb.sv ----
// Testbench for the battery class request handler
`timescale 1ns/1ps
module pdb_battery_requests_tb import pdb_pkg::*; ();
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic hready, hreadyout, hresp, txValid, txLast, txReady, reqAck, reqStall, wakeOut, irq;
	logic setupValid;
	logic [31:0] hrdata, rv;
	logic [7:0] txData, setupType, setupCode;
	logic [15:0] setupValue, setupIndex, setupLength;
	logic [63:0] rec;
	logic [1:0] hs;
	int miscompares = 0;
	int n_compared = 0;
	int cyc = 0;
	int wakes = 0;
	assign hready = hreadyout;
	pdb_battery_requests #(.NCELL(2)) pdb_battery_requests_i (.clk, .rst, .ce, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .setupValid,
		.setupType, .setupCode, .setupValue, .setupIndex, .setupLength, .txValid, .txData,
		.txLast, .txReady, .reqAck, .reqStall, .wakeOut, .irq);
	pdb_host_model pdb_host_model_i (.clk, .txValid, .txData, .reqAck, .reqStall, .setupValid,
		.setupType, .setupCode, .setupValue, .setupIndex, .setupLength, .txReady);
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic test_done;
		$display("compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : test_done
	always @(posedge clk) begin
		cyc++;
		if (wakeOut === 1'b1)
			wakes++;
		if (cyc == 3000) begin
			miscompares++;
			test_done;
		end
	end
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rv = hrdata;
		chk({63'h0, hresp}, {63'h0, HRESP_OKAY[0]}, "bus response");
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk({32'h0, rv}, {32'h0, exp}, "register");
	endtask : rd
	task automatic get(input logic [15:0] v, input logic [15:0] i, input bit slow);
		pdb_host_model_i.req({REQTYPE_GET_CELL, REQ_GET_CELL, v, i, 16'h0008}, slow, rec, hs);
	endtask : get
	task automatic feat(input logic [15:0] v, input logic [15:0] i, input logic [15:0] l);
		pdb_host_model_i.req({REQTYPE_SET_FEATURE, REQ_SET_FEATURE, v, i, l}, 1'b0, rec, hs);
	endtask : feat
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFS_CTRL, 32'h3);
		rd(8'h40, 32'h0);
		bus(1'b1, OFS_IRQ_ENABLE, 32'hF);
		bus(1'b1, OFS_CELL_BASE, 32'h0009C801);
		rd(OFS_CELL_BASE, 32'h00076401);
		bus(1'b1, OFS_CELL_BASE, 32'h00003205);
		rd(OFS_CELL_BASE, 32'h00003201);
		bus(1'b1, OFS_CELL_BASE + 8'h4, 32'h00031002);
		get(16'h0, 16'h0, 1'b0);
		chk(rec, 64'h3201, "cell 0 record");
		get(16'h0, 16'h1, 1'b1);
		chk(rec, 64'h31002, "cell 1 record");
		bus(1'b1, OFS_CELL_BASE + 8'h4, 32'h00031000);
		rd(OFS_CELL_BASE + 8'h4, 32'h00001000);
		get(16'h1, 16'h0, 1'b0);
		chk({62'h0, hs}, 64'h1, "value refusal");
		get(16'h0, 16'h2, 1'b0);
		chk({62'h0, hs}, 64'h1, "index refusal");
		feat(SEL_CELL_WAKE, 16'h0100, 16'h0);
		chk({62'h0, hs}, 64'h2, "wake feature");
		feat(SEL_CHARGE_POLICY, 16'h005A, 16'h0);
		rd(OFS_POLICY, 32'h5A);
		feat(16'h0029, 16'h0, 16'h0);
		chk({62'h0, hs}, 64'h1, "selector refusal");
		feat(SEL_CHARGE_POLICY, 16'h1, 16'h1);
		chk({62'h0, hs}, 64'h1, "length refusal");
		// Only the masked cell may wake
		bus(1'b1, OFS_CELL_BASE, 32'h00003301);
		bus(1'b1, OFS_CELL_BASE + 8'h4, 32'h00003301);
		repeat (4) @(posedge clk);
		chk(wakes, 64'h1, "wake events");
		rd(OFS_CELL_BASE, 32'h01003301);
		rd(OFS_IRQ_STATUS, 32'hF);
		chk({63'h0, irq}, 64'h1, "irq raised");
		bus(1'b1, OFS_IRQ_CLEAR, 32'hF);
		bus(1'b1, OFS_IRQ_ENABLE, 32'h0);
		repeat (2) @(posedge clk);
		chk({63'h0, irq}, 64'h0, "irq cleared");
		bus(1'b1, OFS_CTRL, 32'h2);
		get(16'h0, 16'h0, 1'b0);
		chk({62'h0, hs}, 64'h1, "no battery refusal");
		rd(OFS_IRQ_STATUS, 32'h4);
		chk({63'h0, irq}, 64'h0, "irq masked");
		bus(1'b1, OFS_IRQ_ENABLE, 32'h4);
		repeat (2) @(posedge clk);
		chk({63'h0, irq}, 64'h1, "irq unmasked");
		test_done;
	end
endmodule : pdb_battery_requests_tb

// ---- bench/pdb_checker.sv ----
// Port checker for the battery request handler
`timescale 1ns/1ps
module pdb_checker import pdb_pkg::*; #(
	parameter int NCELL = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic setupValid,
	input wire logic [7:0] setupType,
	input wire logic [7:0] setupCode,
	input wire logic [15:0] setupValue,
	input wire logic [15:0] setupIndex,
	input wire logic [15:0] setupLength,
	input wire logic txValid,
	input wire logic [7:0] txData,
	input wire logic txLast,
	input wire logic txReady,
	input wire logic reqAck,
	input wire logic reqStall
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic [2:0] pos;
	wire setup = setupValid && ce;
	wire getReq = setup && setupType == REQTYPE_GET_CELL && setupCode == REQ_GET_CELL;
	wire setReq = setup && setupType == REQTYPE_SET_FEATURE && setupCode == REQ_SET_FEATURE;
	wire known = setupValue == SEL_CELL_WAKE || setupValue == SEL_CHARGE_POLICY;
	wire shown = txValid && ce;
	// Byte position in the record; any setup restarts it
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			pos <= 3'h0;
		else if (setup)
			pos <= 3'h0;
		else if (shown && txReady)
			pos <= pos + 3'h1;
	end
	get_answer_a: assert property (getReq && setupValue == VALUE_ZERO
		&& setupIndex < NCELL |=> txValid ^ reqStall) else $error("status request unanswered");
	value_stall_a: assert property (getReq && setupValue != VALUE_ZERO
		|=> reqStall && !txValid) else $error("nonzero value not refused");
	index_stall_a: assert property (getReq && setupIndex >= NCELL |=> reqStall)
		else $error("unknown battery not refused");
	feat_len_a: assert property (setReq && setupLength != LENGTH_ZERO
		|=> reqStall && !reqAck) else $error("feature with data not refused");
	sel_known_a: assert property (setReq && !known |=> reqStall)
		else $error("unknown selector not refused");
	feat_answer_a: assert property (setReq && setupValue == SEL_CHARGE_POLICY
		&& setupLength == LENGTH_ZERO |=> reqAck ^ reqStall) else $error("feature unanswered");
	tx_hold_a: assert property (shown && !txReady && !setupValid
		|=> txValid && $stable(txData)) else $error("byte dropped before accept");
	presence_code_a: assert property (shown && pos == 3'h0 |-> txData <= ATTR_MAX)
		else $error("reserved presence code");
	charge_pct_a: assert property (shown && pos == 3'h1 |-> txData <= SOC_MAX)
		else $error("charge above full");
	fault_code_a: assert property (shown && pos == 3'h2 |-> txData <= FAULT_MAX)
		else $error("reserved fault code");
	pad_zero_a: assert property (shown && pos[2] |-> txData == 8'h00)
		else $error("padding byte not zero");
	last_byte_a: assert property (shown |-> txLast == (pos == RECORD_LAST))
		else $error("last flag misplaced");
	cover property (shown && txLast && txReady);
	cover property (reqAck);
	cover property (reqStall);
endmodule : pdb_checker
bind pdb_battery_requests pdb_checker #(.NCELL(NCELL)) pdb_checker_i (.clk, .rst, .ce,
	.setupValid, .setupType, .setupCode, .setupValue, .setupIndex, .setupLength,
	.txValid, .txData, .txLast, .txReady, .reqAck, .reqStall);

// ---- bench/pdb_host_model.sv ----
// Host side model: issues setups and takes the data stage
`timescale 1ns/1ps
module pdb_host_model import pdb_pkg::*; (
	input wire logic clk,
	input wire logic txValid,
	input wire logic [7:0] txData,
	input wire logic reqAck,
	input wire logic reqStall,
	output logic setupValid,
	output logic [7:0] setupType,
	output logic [7:0] setupCode,
	output logic [15:0] setupValue,
	output logic [15:0] setupIndex,
	output logic [15:0] setupLength,
	output logic txReady
);
	initial begin
		setupValid = 1'b0;
		{setupType, setupCode, setupValue, setupIndex, setupLength} = 64'h0;
		txReady = 1'b0;
	end
	// Slow mode takes a byte only every other cycle
	task automatic req(input logic [63:0] f, input bit slow,
		output logic [63:0] rec, output logic [1:0] hs);
		int k;
		rec = 64'h0;
		hs = 2'b00;
		k = 0;
		@(posedge clk);
		setupValid <= 1'b1;
		{setupType, setupCode, setupValue, setupIndex, setupLength} <= f;
		@(posedge clk);
		setupValid <= 1'b0;
		// Fields no longer qualified, so they must not look valid
		{setupType, setupCode, setupValue, setupIndex, setupLength} <= ~f;
		txReady <= 1'b1;
		repeat (24) begin
			@(posedge clk);
			hs = hs | {reqAck, reqStall};
			if (txValid && txReady && k < 8) begin
				rec[8*k+:8] = txData;
				k++;
			end
			txReady <= slow ? ~txReady : 1'b1;
		end
		txReady <= 1'b0;
	endtask : req
endmodule : pdb_host_model

// ---- core/pdb_battery_requests.sv ----
// Battery class request handler with AHB-Lite register access
`timescale 1ns/1ps
module pdb_battery_requests import pdb_pkg::*; #(
	parameter int NCELL = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Setup packet from the control endpoint
	input wire logic setupValid,
	input wire logic [7:0] setupType,
	input wire logic [7:0] setupCode,
	input wire logic [15:0] setupValue,
	input wire logic [15:0] setupIndex,
	input wire logic [15:0] setupLength,
	// Data stage toward the host
	output logic txValid,
	output logic [7:0] txData,
	output logic txLast,
	input wire logic txReady,
	// Handshakes and events
	output logic reqAck,
	output logic reqStall,
	output logic wakeOut,
	output logic irq
);
	localparam int IDXW = NCELL > 1 ? $clog2(NCELL) : 1;

	typedef enum logic [0:0] {ST_IDLE, ST_SEND} pdb_state_e;

	pdb_state_e state;
	logic [CTRL_W-1:0] ctrl;
	logic [IRQ_W-1:0] irqStatus;
	logic [IRQ_W-1:0] irqEnable;
	logic [7:0] policy;
	logic [63:0] txShift;
	logic [2:0] byteCnt;
	logic wPend;
	logic [7:0] wAddr;

	// Decoder outputs
	logic isStatus;
	logic isFeature;
	logic statusOk;
	logic featureOk;
	logic featWake;
	logic featPolicy;

	// Record store
	logic [NCELL*32-1:0] records;
	logic [NCELL-1:0] wakeHit;
	logic [31:0] recSel;
	logic cellWr;
	logic [IDXW-1:0] cellWrIdx;
	logic wakeWr;

	// Bus decode
	logic addrPhase;
	logic rdPhase;
	logic [7:0] aAddr;
	logic [5:0] rdCellWord;
	logic [5:0] wrCellWord;
	logic rdIsCell;
	logic wrIsCell;
	logic [31:0] rdCell;
	logic [31:0] readValue;
	logic wrCtrl;
	logic wrClear;
	logic wrEnable;
	logic [IRQ_W-1:0] clearBits;

	// Request outcomes
	logic takeStatus;
	logic takeFeature;
	logic refuse;
	logic wakeEvent;
	logic txAdvance;
	logic [IRQ_W-1:0] irqEvents;
	logic [IRQ_W-1:0] next_irqStatus;
	logic [IRQ_W-1:0] next_irqEnable;
	logic inWindow;
	logic [IDXW-1:0] reqCellIdx;
	logic [IDXW-1:0] rdCellIdx;
	logic rdCtrl;
	logic rdStatus;
	logic rdEnable;
	logic rdPolicy;

	// Data stage steps
	logic txStep;
	logic txFinal;
	logic [2:0] next_byteCnt;
	logic [63:0] next_txShift;

	pdb_setup_decode #(
		.NCELL(NCELL)
	) uDecode (
		.reqType(setupType),
		.reqCode(setupCode),
		.reqValue(setupValue),
		.reqIndex(setupIndex),
		.reqLength(setupLength),
		.fitted(ctrl[CTRL_FITTED]),
		.wakeCap(ctrl[CTRL_WAKE_CAP]),
		.isStatus(isStatus),
		.isFeature(isFeature),
		.statusOk(statusOk),
		.featureOk(featureOk),
		.featWake(featWake),
		.featPolicy(featPolicy)
	);

	pdb_cell_store #(
		.NCELL(NCELL),
		.IDXW(IDXW)
	) uStore (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.wrEn(cellWr),
		.wrIdx(cellWrIdx),
		.wrData(hwdata),
		.wakeEn(wakeWr),
		.wakeIdx(reqCellIdx),
		.wakeData(setupIndex[15:8]),
		.records(records),
		.wakeHit(wakeHit)
	);

	// Setup outcomes; requests of other classes are left to the endpoint core
	assign takeStatus = setupValid && isStatus && statusOk;
	assign takeFeature = setupValid && isFeature && featureOk;
	assign refuse = setupValid && ((isStatus && !statusOk) || (isFeature && !featureOk));
	assign wakeWr = takeFeature && featWake;
	assign reqCellIdx = setupIndex[IDXW-1:0];
	// Only the addressed battery's record goes out
	assign recSel = records[32*32'(reqCellIdx) +: 32];
	assign wakeEvent = ctrl[CTRL_WAKE_CAP] && |wakeHit;
	assign txAdvance = state == ST_SEND && txValid && txReady;

	// Byte steps decoded here so the state register stays small
	assign txStep = txAdvance && byteCnt != RECORD_LAST;
	assign txFinal = txAdvance && byteCnt == RECORD_LAST;
	assign next_byteCnt = byteCnt + 3'h1;
	assign next_txShift = txShift >> 8;

	// Register decode: address phase for reads, data phase for writes
	assign addrPhase = hsel && hready && htrans == HTRANS_NONSEQ;
	assign rdPhase = addrPhase && !hwrite;
	// Only the low 256 bytes are mapped; the rest reads zero
	assign inWindow = haddr[31:8] == 24'h000000;
	assign aAddr = haddr[7:0];
	assign rdCellWord = aAddr[7:2] - OFS_CELL_BASE[7:2];
	assign wrCellWord = wAddr[7:2] - OFS_CELL_BASE[7:2];
	assign rdIsCell = aAddr >= OFS_CELL_BASE && 32'(rdCellWord) < NCELL && inWindow;
	assign wrIsCell = wAddr >= OFS_CELL_BASE && 32'(wrCellWord) < NCELL;
	assign rdCellIdx = rdCellWord[IDXW-1:0];
	assign rdCell = records[32*32'(rdCellIdx) +: 32];
	assign rdCtrl = aAddr == OFS_CTRL;
	assign rdStatus = aAddr == OFS_IRQ_STATUS;
	assign rdEnable = aAddr == OFS_IRQ_ENABLE;
	assign rdPolicy = aAddr == OFS_POLICY;
	// Read data is taken in the address phase: a read right behind a write
	// to the same register sees the old value, so masters leave one idle cycle
	assign readValue = rdIsCell ? rdCell
		: !inWindow ? 32'h00000000
		: rdCtrl ? 32'(ctrl)
		: rdStatus ? 32'(irqStatus)
		: rdEnable ? 32'(irqEnable)
		: rdPolicy ? 32'(policy)
		: 32'h00000000;
	assign wrCtrl = wPend && wAddr == OFS_CTRL;
	assign wrClear = wPend && wAddr == OFS_IRQ_CLEAR;
	assign wrEnable = wPend && wAddr == OFS_IRQ_ENABLE;
	assign cellWr = wPend && wrIsCell;
	assign cellWrIdx = wrCellWord[IDXW-1:0];
	assign clearBits = wrClear ? hwdata[IRQ_W-1:0] : '0;

	// Set wins over a clear in the same cycle
	assign irqEvents = {wakeEvent, refuse, takeFeature, takeStatus};
	assign next_irqStatus = (irqStatus & ~clearBits) | irqEvents;
	// Irq follows an enable write at once, not one cycle later
	assign next_irqEnable = wrEnable ? hwdata[IRQ_W-1:0] : irqEnable;

	// Bus slave: zero wait states, always OKAY
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
			wPend <= 1'b0;
			wAddr <= 8'h00;
		end else if (ce) begin
			hreadyout <= 1'b1;
			hresp <= HRESP_OKAY[0];
			wPend <= addrPhase && hwrite && inWindow;
			wAddr <= aAddr;
			if (rdPhase) begin
				hrdata <= readValue;
			end
		end
	end

	// Software registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl <= CTRL_RST;
			irqEnable <= '0;
			irqStatus <= '0;
			irq <= 1'b0;
		end else if (ce) begin
			if (wrCtrl) begin
				ctrl <= hwdata[CTRL_W-1:0];
			end
			irqEnable <= next_irqEnable;
			irqStatus <= next_irqStatus;
			irq <= |(next_irqStatus & next_irqEnable);
		end
	end

	// Charging policy is held for firmware to act on
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			policy <= 8'h00;
		end else if (ce && takeFeature && featPolicy) begin
			policy <= setupIndex[7:0];
		end
	end

	// Handshake and wake pulses
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reqAck <= 1'b0;
			reqStall <= 1'b0;
			wakeOut <= 1'b0;
		end else if (ce) begin
			reqAck <= takeFeature;
			reqStall <= refuse;
			wakeOut <= wakeEvent;
		end
	end

	// Data stage: eight bytes, low byte first; a new setup aborts a transfer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			txShift <= 64'h0000000000000000;
			byteCnt <= 3'h0;
			txValid <= 1'b0;
			txData <= 8'h00;
			txLast <= 1'b0;
		end else if (ce) begin
			if (takeStatus) begin
				state <= ST_SEND;
				txShift <= {32'h00000000, recSel};
				byteCnt <= 3'h0;
				txValid <= 1'b1;
				txData <= recSel[7:0];
				txLast <= 1'b0;
			end else if (setupValid) begin
				// A new setup drops any byte still waiting
				state <= ST_IDLE;
				txValid <= 1'b0;
				txLast <= 1'b0;
			end else begin
				case (state)
					ST_IDLE: begin
						txValid <= 1'b0;
						txLast <= 1'b0;
					end
					ST_SEND: begin
						if (txFinal) begin
							state <= ST_IDLE;
							txValid <= 1'b0;
							txLast <= 1'b0;
						end else if (txStep) begin
							byteCnt <= next_byteCnt;
							txShift <= next_txShift;
							txData <= next_txShift[7:0];
							txLast <= byteCnt == RECORD_PRELAST;
						end
					end
					default: begin
						state <= ST_IDLE;
						txValid <= 1'b0;
					end
				endcase
			end
		end
	end
endmodule : pdb_battery_requests

// ---- core/pdb_cell_store.sv ----
// Per-battery status records with change detection
`timescale 1ns/1ps
module pdb_cell_store import pdb_pkg::*; #(
	parameter int NCELL = 2,
	parameter int IDXW = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic wrEn,
	input wire logic [IDXW-1:0] wrIdx,
	input wire logic [31:0] wrData,
	input wire logic wakeEn,
	input wire logic [IDXW-1:0] wakeIdx,
	input wire logic [7:0] wakeData,
	output logic [NCELL*32-1:0] records,
	output logic [NCELL-1:0] wakeHit
);
	genvar g;
	generate
		for (g = 0; g < NCELL; g++) begin : gCell
			logic [7:0] attr;
			logic [7:0] soc;
			logic [7:0] fault;
			logic [7:0] wake;
			logic changed;
			logic hit;
			logic [7:0] next_attr;
			logic [7:0] next_soc;
			logic [7:0] next_fault;
			logic [7:0] rawFault;

			assign hit = wrEn && wrIdx == IDXW'(g);
			// Reserved presence code leaves the old value in place
			assign next_attr = wrData[ATTR_LSB +: 8] > ATTR_MAX ? attr : wrData[ATTR_LSB +: 8];
			assign next_soc = wrData[SOC_LSB +: 8] > SOC_MAX ? SOC_MAX : wrData[SOC_LSB +: 8];
			assign rawFault = wrData[FAULT_LSB +: 8] > FAULT_MAX ? FAULT_MAX
				: wrData[FAULT_LSB +: 8];
			assign next_fault = next_attr == ATTR_NONE ? FAULT_NONE : rawFault;

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					attr <= ATTR_NONE;
					soc <= 8'h00;
					fault <= FAULT_NONE;
					wake <= 8'h00;
					changed <= 1'b0;
				end else if (ce) begin
					changed <= hit && {next_attr, next_soc, next_fault} != {attr, soc, fault};
					if (hit) begin
						attr <= next_attr;
						soc <= next_soc;
						fault <= next_fault;
					end
					if (wakeEn && wakeIdx == IDXW'(g)) begin
						wake <= wakeData;
					end
				end
			end

			assign records[g*32 +: 32] = {wake, fault, soc, attr};
			assign wakeHit[g] = changed && wake != 8'h00;
		end
	endgenerate
endmodule : pdb_cell_store

// ---- core/pdb_pkg.sv ----
// Constants shared by the battery class request handler
// Operation
// - Battery requests are served only while a battery is fitted; else refused
// - Status request: type 80h, value zero, index is battery id, eight bytes returned
// - Request code 21 decodes as the battery status request
// - Feature set request: type 00h, set-feature code, selector in value, no data
// - Selector 40 sets the wake mask, selector 54 the charging policy
// - Returned record is the one of the battery named by the index field
// - Each battery keeps its own record; never an aggregate
// - Presence byte only 0 to 3; reserved codes are never stored or returned
// - State of charge is a percentage, held at 100 at most
// - Fault byte carries meaning only while a battery is present, else zero
// - Fault codes 0 to 7; anything higher is reported as unspecified error
// - Wake mask defaults off, set by host; enabled status change raises wake
package pdb_pkg;
	// Setup packet codes
	localparam logic [7:0] REQTYPE_GET_CELL = 8'h80;
	localparam logic [7:0] REQTYPE_SET_FEATURE = 8'h00;
	localparam logic [7:0] REQ_GET_CELL = 8'h15;
	localparam logic [7:0] REQ_SET_FEATURE = 8'h03;
	localparam logic [15:0] SEL_CELL_WAKE = 16'h0028;
	localparam logic [15:0] SEL_CHARGE_POLICY = 16'h0036;
	localparam logic [15:0] VALUE_ZERO = 16'h0000;
	localparam logic [15:0] LENGTH_ZERO = 16'h0000;
	localparam logic [2:0] RECORD_LAST = 3'h7;
	localparam logic [2:0] RECORD_PRELAST = 3'h6;
	// Record field codes
	localparam logic [7:0] ATTR_NONE = 8'h00;
	localparam logic [7:0] ATTR_MAX = 8'h03;
	localparam logic [7:0] SOC_MAX = 8'h64;
	localparam logic [7:0] FAULT_NONE = 8'h00;
	localparam logic [7:0] FAULT_MAX = 8'h07;
	localparam int ATTR_LSB = 0;
	localparam int SOC_LSB = 8;
	localparam int FAULT_LSB = 16;
	localparam int WAKE_LSB = 24;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h04;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h08;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h0C;
	localparam logic [7:0] OFS_POLICY = 8'h10;
	localparam logic [7:0] OFS_CELL_BASE = 8'h20;
	// Control bits
	localparam int CTRL_FITTED = 0;
	localparam int CTRL_WAKE_CAP = 1;
	localparam int CTRL_W = 2;
	localparam logic [CTRL_W-1:0] CTRL_RST = 2'h3;
	// Interrupt bits
	localparam int IRQ_SERVED = 0;
	localparam int IRQ_FEATURE = 1;
	localparam int IRQ_REFUSED = 2;
	localparam int IRQ_WAKE = 3;
	localparam int IRQ_W = 4;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage : pdb_pkg

// ---- core/pdb_setup_decode.sv ----
// Setup packet decoder for the battery class requests
`timescale 1ns/1ps
module pdb_setup_decode import pdb_pkg::*; #(
	parameter int NCELL = 2
) (
	input wire logic [7:0] reqType,
	input wire logic [7:0] reqCode,
	input wire logic [15:0] reqValue,
	input wire logic [15:0] reqIndex,
	input wire logic [15:0] reqLength,
	input wire logic fitted,
	input wire logic wakeCap,
	output logic isStatus,
	output logic isFeature,
	output logic statusOk,
	output logic featureOk,
	output logic featWake,
	output logic featPolicy
);
	logic idxValid;
	logic wakeIdxValid;

	assign isStatus = reqType == REQTYPE_GET_CELL && reqCode == REQ_GET_CELL;
	assign isFeature = reqType == REQTYPE_SET_FEATURE && reqCode == REQ_SET_FEATURE;
	assign idxValid = 32'(reqIndex) < NCELL;
	assign wakeIdxValid = 32'(reqIndex[7:0]) < NCELL;
	assign featWake = reqValue == SEL_CELL_WAKE;
	assign featPolicy = reqValue == SEL_CHARGE_POLICY;
	// No battery fitted: nothing to report, so refuse
	assign statusOk = fitted && reqValue == VALUE_ZERO && idxValid;
	// Wake feature needs remote wake ability and a real battery
	assign featureOk = fitted && reqLength == LENGTH_ZERO
		&& ((featWake && wakeCap && wakeIdxValid) || featPolicy);
endmodule : pdb_setup_decode
